//--- src/cces_pkg.sv
// constants, field layout and types of the channel error supervisor
// assumes a plain register port with byte offsets on a 4-bit address
package cces_pkg;

  // register offsets (byte addresses, one word each)
  localparam logic [3:0] ADDR_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_FLAGS = 4'h4;
  localparam logic [3:0] ADDR_STAT  = 4'h8;

  // control register fields
  localparam int CTRL_IE_LSB   = 0;
  localparam int CTRL_ABT_EN   = 8;
  localparam int CTRL_BOM_LSB  = 9;
  localparam int CTRL_ERROR_DISPLAY_SEL     = 11;
  localparam int CTRL_MODE_LSB = 12;
  localparam int CTRL_BOHALT   = 14;
  localparam logic [1:0] CTRL_MODE_RST = 2'h1;

  // error flag register fields
  localparam int FLAG_KIND_LSB = 8;
  localparam int FLAG_KIND_MSB = 14;

  // status register fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_BUSOFF   = 2;
  localparam int STAT_WARN     = 3;
  localparam int STAT_PASSIVE  = 4;
  localparam int STAT_ABORT    = 5;
  localparam int STAT_TEC_LSB  = 8;
  localparam int STAT_REC_LSB  = 24;

  // channel mode codes
  localparam logic [1:0] MODE_COMM  = 2'h0;
  localparam logic [1:0] MODE_RESET = 2'h1;
  localparam logic [1:0] MODE_HALT  = 2'h2;

  // bus-off recovery selections
  localparam logic [1:0] BOM_STD   = 2'h0;
  localparam logic [1:0] BOM_ENTRY = 2'h1;
  localparam logic [1:0] BOM_EXIT  = 2'h2;
  localparam logic [1:0] BOM_SOFT  = 2'h3;

  // error counter limits and bit counts
  localparam int unsigned WARN_LIMIT    = 95;
  localparam int unsigned PASSIVE_LIMIT = 127;
  localparam int unsigned BUSOFF_LIMIT  = 255;
  localparam int unsigned RECOV_RUN     = 11;
  localparam int unsigned RECOV_SEQ     = 128;
  localparam int unsigned LOCK_RUN      = 32;

  // channel modes
  typedef enum logic [1:0] {CH_COMM, CH_RESET, CH_HALT} cces_mode_t;

  // error events reported by the protocol engine, one-cycle pulses
  typedef struct packed {
    logic ack_delim;
    logic crc;
    logic ack;
    logic form;
    logic stuff;
  } cces_evt_t;

  // error kind flags, msb lands on bit 14 of the flag register
  typedef struct packed {
    logic ack_delim_err_flag;
    logic bit_zero_err_flag;
    logic bit_one_err_flag;
    logic crc_err_flag;
    logic ack_err_flag;
    logic form_err_flag;
    logic stuff_err_flag;
  } cces_kind_t;

endpackage

//--- src/cces_top.sv
// channel error supervisor: error flags, channel error interrupts,
// bus-off recovery selection, error display mode and channel modes
// assumes engine inputs on mclk_i; can_rx_i is an asynchronous pin
//
// Functional notes
// - error interrupt gated by per-source software enables
// - ack delimiter form error sets its flag
// - sent dominant, saw recessive sets bit-zero flag
// - sent recessive, saw dominant sets bit-one flag
// - crc, ack, form, stuff errors set flags
// - warning interrupt on first counter above 95
// - passive interrupt on first counter above 127
// - transmit counter above 255 enters bus-off
// - halt-on-entry bus-off also raises entry interrupt
// - recovery after 128 runs of 11 recessive
// - overload condition raises overload interrupt
// - 32 dominant bits while communicating means lockup
// - lost arbitration raises arbitration lost interrupt
// - enabled abort completion raises transmit interrupt
// - recovery field 00 std, 01 entry, 10 exit
// - field 11 halts on software request in bus-off
// - error kinds occupy flag bits 14 to 8
// - display select 0 keeps first event only
// - display select 1 records every error event
// - channel mode requests accepted in every state
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module cces_top
  import cces_pkg::*;
#(
  parameter int unsigned WARN_LIM  = WARN_LIMIT,
  parameter int unsigned PASS_LIM  = PASSIVE_LIMIT,
  parameter int unsigned BOFF_LIM  = BUSOFF_LIMIT,
  parameter int unsigned REC_RUN   = RECOV_RUN,
  parameter int unsigned REC_SEQ   = RECOV_SEQ,
  parameter int unsigned LOCK_BITS = LOCK_RUN
) (
  input  wire logic        mclk_i,        // controller clock
  input  wire logic        rst_b_i,       // async reset, active low
  input  wire logic [3:0]  reg_addr_i,    // register byte address
  input  wire logic [31:0] reg_wdata_i,   // register write data
  input  wire logic        reg_wr_i,      // write strobe
  input  wire logic        reg_rd_i,      // read strobe
  output logic      [31:0] reg_rdata_o,   // read data, next cycle
  input  wire logic        can_rx_i,      // bus level pin, 1 recessive
  input  wire logic        can_tx_i,      // level being driven now
  input  wire logic        bit_tick_i,    // sample point pulse
  input  wire logic        bit_chk_i,     // bit monitoring active
  input  wire cces_evt_t   err_evt_i,     // engine error pulses
  input  wire logic [8:0]  tec_i,         // transmit error counter
  input  wire logic [7:0]  rec_i,         // receive error counter
  input  wire logic        ovl_evt_i,     // overload condition pulse
  input  wire logic        arb_lost_i,    // arbitration lost pulse
  input  wire logic        abort_done_i,  // abort completed pulse
  input  wire logic        comm_active_i, // channel transferring
  output logic      [1:0]  chan_mode_o,   // current channel mode
  output logic             busoff_o,      // bus-off state
  output logic             chan_err_irq_o,// channel error interrupt
  output logic             chan_tx_irq_o  // abort part of tx interrupt
);

  localparam int RUN_W  = $clog2(REC_RUN + 1);
  localparam int SEQ_W  = $clog2(REC_SEQ + 1);
  localparam int LOCK_W = $clog2(LOCK_BITS + 1);
  localparam logic [RUN_W-1:0]  RUN_LAST  = RUN_W'(REC_RUN - 1);
  localparam logic [SEQ_W-1:0]  SEQ_LAST  = SEQ_W'(REC_SEQ - 1);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_BITS - 1);

  // counter compared against a limit
  function automatic logic above(input logic [8:0] cnt,
                                 input int unsigned lim);
    above = (32'(cnt) > lim);
  endfunction

  // mode to its register code
  function automatic logic [1:0] mode_code(input cces_mode_t m);
    case (m)
      CH_COMM:  mode_code = MODE_COMM;
      CH_RESET: mode_code = MODE_RESET;
      CH_HALT:  mode_code = MODE_HALT;
      default:  mode_code = MODE_RESET;
    endcase
  endfunction

  // reset release and pin synchroniser
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic       rx_meta_q;
  logic       rx_q;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta_q <= 1'b1;
      rx_q      <= 1'b1;
    end else begin
      rx_meta_q <= can_rx_i;
      rx_q      <= rx_meta_q;
    end
  end

  // state registers
  logic [8:0]        ie_q;
  logic [1:0]        bom_q;
  logic              error_display_sel_q;
  cces_mode_t        mode_q;
  cces_mode_t        mode_d;
  logic [14:0]       flags_q;
  logic [14:0]       flags_d;
  logic              abort_q;
  logic              abort_d;
  logic              warn_q;
  logic              pass_q;
  logic              tec_hi_q;
  logic              busoff_q;
  logic              busoff_d;
  logic [RUN_W-1:0]  run_q;
  logic [RUN_W-1:0]  run_d;
  logic [SEQ_W-1:0]  seq_q;
  logic [SEQ_W-1:0]  seq_d;
  logic [LOCK_W-1:0] lock_q;
  logic [LOCK_W-1:0] lock_d;
  logic [31:0]       rdata_q;
  logic              err_irq_q;
  logic              tx_irq_q;

  // register port decode
  wire wr_ctrl  = reg_wr_i && (reg_addr_i == ADDR_CTRL);
  wire wr_flags = reg_wr_i && (reg_addr_i == ADDR_FLAGS);
  wire wr_stat  = reg_wr_i && (reg_addr_i == ADDR_STAT);
  wire [1:0] req_mode = reg_wdata_i[CTRL_MODE_LSB +: 2];
  wire bohalt_req = wr_ctrl && reg_wdata_i[CTRL_BOHALT];

  // bit monitoring at the sample point
  wire chk     = bit_tick_i && bit_chk_i;
  wire bit0_ev = chk && !can_tx_i && rx_q;
  wire bit1_ev = chk && can_tx_i && !rx_q;

  // error kinds seen this cycle
  cces_kind_t kind_ev;
  assign kind_ev.ack_delim_err_flag = err_evt_i.ack_delim;
  assign kind_ev.bit_zero_err_flag  = bit0_ev;
  assign kind_ev.bit_one_err_flag   = bit1_ev;
  assign kind_ev.crc_err_flag       = err_evt_i.crc;
  assign kind_ev.ack_err_flag       = err_evt_i.ack;
  assign kind_ev.form_err_flag      = err_evt_i.form;
  assign kind_ev.stuff_err_flag     = err_evt_i.stuff;
  wire any_kind = |kind_ev;

  // display mode: first event only, or every event; kinds cleared in
  // the same cycle count as clear, so a new first event still lands
  wire [14:0] flag_clr = wr_flags ? reg_wdata_i[14:0] : 15'h0000;
  wire [6:0]  kind_left = flags_q[FLAG_KIND_MSB:FLAG_KIND_LSB] &
                          ~flag_clr[FLAG_KIND_MSB:FLAG_KIND_LSB];
  wire kind_clear = (kind_left == 7'h00);
  wire [6:0] kind_set = error_display_sel_q ? 7'(kind_ev)
                      : (kind_clear ? 7'(kind_ev) : 7'h00);

  // error state levels and their first detection
  wire warn_lvl = above(tec_i, WARN_LIM) ||
                  above({1'b0, rec_i}, WARN_LIM);
  wire pass_lvl = above(tec_i, PASS_LIM) ||
                  above({1'b0, rec_i}, PASS_LIM);
  wire tec_hi   = above(tec_i, BOFF_LIM);
  wire warn_ev  = warn_lvl && !warn_q;
  wire pass_ev  = pass_lvl && !pass_q;

  // bus-off entry on the crossing above the limit
  wire bo_enter = tec_hi && !tec_hi_q && !busoff_q;

  // recovery: runs of recessive bits counted while bus-off
  wire rec_tick = busoff_q && bit_tick_i;
  wire run_end  = rec_tick && rx_q && (run_q == RUN_LAST);
  wire bo_exit  = run_end && (seq_q == SEQ_LAST);

  // lockup: consecutive dominant samples while communicating
  wire lock_tick = comm_active_i && bit_tick_i && !rx_q;
  wire lock_ev   = lock_tick && (lock_q == LOCK_LAST);

  // interrupt source pulses, bit order of flag bits 7..0
  wire [7:0] src_ev = {arb_lost_i,
                       lock_ev,
                       ovl_evt_i,
                       bo_exit,
                       bo_enter,
                       pass_ev,
                       warn_ev,
                       any_kind};

  // flag register next value, a new event beats a clear
  always_comb begin
    flags_d = flags_q & ~flag_clr;
    flags_d[FLAG_KIND_MSB:FLAG_KIND_LSB] =
      flags_d[FLAG_KIND_MSB:FLAG_KIND_LSB] | kind_set;
    flags_d[7:0] = flags_d[7:0] | src_ev;
  end

  // abort completion flag, cleared from the status word
  wire abort_clr = wr_stat && reg_wdata_i[STAT_ABORT];
  assign abort_d = (abort_q && !abort_clr) || abort_done_i;

  // recovery counters
  always_comb begin
    run_d = run_q;
    seq_d = seq_q;
    if (!busoff_q) begin
      run_d = '0;
      seq_d = '0;
    end else if (rec_tick) begin
      if (!rx_q) begin
        run_d = '0;
      end else if (run_end) begin
        run_d = '0;
        seq_d = SEQ_W'(seq_q + 1'b1);
      end else begin
        run_d = RUN_W'(run_q + 1'b1);
      end
    end
  end

  // bus-off state
  always_comb begin
    busoff_d = busoff_q;
    if (bo_enter) begin
      busoff_d = 1'b1;
    end else if (bo_exit) begin
      busoff_d = 1'b0;
    end
  end

  // dominant run counter, saturates once lockup is declared
  always_comb begin
    lock_d = lock_q;
    if (!comm_active_i) begin
      lock_d = '0;
    end else if (bit_tick_i) begin
      if (rx_q) begin
        lock_d = '0;
      end else if (lock_q != LOCK_W'(LOCK_BITS)) begin
        lock_d = LOCK_W'(lock_q + 1'b1);
      end
    end
  end

  // hardware halt requests per recovery selection
  wire halt_entry = (bom_q == BOM_ENTRY) && bo_enter;
  wire halt_exit  = (bom_q == BOM_EXIT) && bo_exit;
  wire halt_soft  = (bom_q == BOM_SOFT) && busoff_q &&
                    bohalt_req;
  wire hw_halt    = halt_entry || halt_exit || halt_soft;

  // channel mode, software request taken in any mode
  always_comb begin
    mode_d = mode_q;
    if (wr_ctrl) begin
      case (req_mode)
        MODE_COMM:  mode_d = CH_COMM;
        MODE_RESET: mode_d = CH_RESET;
        MODE_HALT:  mode_d = CH_HALT;
        default:    mode_d = mode_q;
      endcase
    end
    if (hw_halt) begin
      mode_d = CH_HALT;
    end
  end

  // control register
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ie_q   <= 9'h000;
      bom_q  <= BOM_STD;
      error_display_sel_q <= 1'b0;
    end else if (wr_ctrl) begin
      ie_q   <= reg_wdata_i[CTRL_ABT_EN:CTRL_IE_LSB];
      bom_q  <= reg_wdata_i[CTRL_BOM_LSB +: 2];
      error_display_sel_q <= reg_wdata_i[CTRL_ERROR_DISPLAY_SEL];
    end
  end

  // mode, flags and error state
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_q   <= CH_RESET;
      flags_q  <= 15'h0000;
      abort_q  <= 1'b0;
      warn_q   <= 1'b0;
      pass_q   <= 1'b0;
      tec_hi_q <= 1'b0;
      busoff_q <= 1'b0;
    end else begin
      mode_q   <= mode_d;
      flags_q  <= flags_d;
      abort_q  <= abort_d;
      warn_q   <= warn_lvl;
      pass_q   <= pass_lvl;
      tec_hi_q <= tec_hi;
      busoff_q <= busoff_d;
    end
  end

  // bit counters
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      run_q  <= '0;
      seq_q  <= '0;
      lock_q <= '0;
    end else begin
      run_q  <= run_d;
      seq_q  <= seq_d;
      lock_q <= lock_d;
    end
  end

  // interrupt outputs, each source gated by its enable
  wire err_irq_d = |(flags_q[7:0] & ie_q[7:0]);
  wire tx_irq_d  = abort_q && ie_q[CTRL_ABT_EN];

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      err_irq_q <= 1'b0;
      tx_irq_q  <= 1'b0;
    end else begin
      err_irq_q <= err_irq_d;
      tx_irq_q  <= tx_irq_d;
    end
  end

  // read words
  wire [31:0] ctrl_word = {17'h00000,
                           1'b0,
                           mode_code(mode_q),
                           error_display_sel_q,
                           bom_q,
                           ie_q};
  wire [31:0] flag_word = {17'h00000, flags_q};
  wire [31:0] stat_word = {rec_i,
                           7'h00,
                           tec_i,
                           2'h0,
                           abort_q,
                           pass_lvl,
                           warn_lvl,
                           busoff_q,
                           mode_code(mode_q)};
  wire [31:0] rd_word = (reg_addr_i == ADDR_CTRL)  ? ctrl_word :
                        (reg_addr_i == ADDR_FLAGS) ? flag_word :
                        (reg_addr_i == ADDR_STAT)  ? stat_word :
                        32'h00000000;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd_i) begin
      rdata_q <= rd_word;
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  // outputs
  assign reg_rdata_o    = rdata_q;
  assign chan_mode_o    = mode_code(mode_q);
  assign busoff_o       = busoff_q;
  assign chan_err_irq_o = err_irq_q;
  assign chan_tx_irq_o  = tx_irq_q;

endmodule

//--- verif/cces_bus_node.sv
// far-side model: the other nodes sharing the bus
// assumes 1 is recessive; the bus resolves as a wired-and
`timescale 1ns/1ps

module cces_bus_node (
  input  wire logic tx_i,    // level our channel drives
  input  wire logic dom_i,   // another node drives dominant
  input  wire logic fault_i, // line stuck recessive on command
  output logic      rx_o     // resolved bus level
);
  // wired-and, plus a stuck-recessive fault for bit errors
  assign rx_o = (tx_i & ~dom_i) | fault_i;
endmodule

//--- verif/cces_top_sva.sv
// port-level assertions for the channel error supervisor
// assumes a bind onto cces_top; one clock, active-low reset
`timescale 1ns/1ps

module cces_top_sva
  import cces_pkg::*;
#(
  parameter int unsigned BOFF_LIM = BUSOFF_LIMIT
) (
  input wire logic        mclk_i,         // clock
  input wire logic        rst_b_i,        // reset, active low
  input wire logic [3:0]  reg_addr_i,     // register address
  input wire logic        reg_wr_i,       // write strobe
  input wire logic        reg_rd_i,       // read strobe
  input wire logic [31:0] reg_wdata_i,    // write data
  input wire logic [31:0] reg_rdata_o,    // read data
  input wire logic        bit_tick_i,     // sample point pulse
  input wire logic [8:0]  tec_i,          // transmit error count
  input wire logic        abort_done_i,   // abort completed
  input wire logic [1:0]  chan_mode_o,    // channel mode
  input wire logic        busoff_o,       // bus-off state
  input wire logic        chan_err_irq_o, // error interrupt
  input wire logic        chan_tx_irq_o   // abort interrupt
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // counter past the bus-off limit
  logic tec_big;
  assign tec_big = (tec_i > 9'(BOFF_LIM));

  // bus-off entry and exit, halt cause and channel mode codes
  a_busoff_entry: assert property ($rose(tec_big) && !busoff_o |=> busoff_o)
    else $error("bus-off not entered");
  a_busoff_cause: assert property ($rose(busoff_o) |-> $past(tec_big))
    else $error("bus-off without counter overflow");
  a_busoff_exit: assert property ($fell(busoff_o) |-> $past(bit_tick_i))
    else $error("bus-off left without a bit");
  a_halt_cause: assert property ($rose(chan_mode_o == MODE_HALT)
    |-> $past(reg_wr_i) || busoff_o || $past(busoff_o))
    else $error("halt without request or bus-off");
  a_mode_legal: assert property (chan_mode_o != 2'h3)
    else $error("illegal channel mode");
  a_mode_keep: assert property (reg_wr_i && reg_addr_i == ADDR_CTRL
    && reg_wdata_i[CTRL_MODE_LSB +: 2] == 2'h3 && !busoff_o && !tec_big
    |=> $stable(chan_mode_o))
    else $error("reserved mode code changed the mode");

  // interrupt outputs follow their causes
  a_tx_irq_rise: assert property ($rose(chan_tx_irq_o)
    |-> $past(abort_done_i, 2) || $past(reg_wr_i, 2))
    else $error("abort interrupt without cause");
  a_tx_irq_fall: assert property ($fell(chan_tx_irq_o) |-> $past(reg_wr_i, 2))
    else $error("abort interrupt dropped alone");
  a_err_irq_fall: assert property ($fell(chan_err_irq_o) |-> $past(reg_wr_i, 2))
    else $error("error interrupt dropped alone");

  // status read mirrors the state
  a_stat_mirror: assert property ($past(reg_rd_i && reg_addr_i == ADDR_STAT)
    |-> reg_rdata_o[2:0] == {$past(busoff_o), $past(chan_mode_o)}
    && reg_rdata_o[16:8] == $past(tec_i))
    else $error("status read mismatch");

  c_halt_busoff: cover property (busoff_o && chan_mode_o == MODE_HALT);
  c_recovered: cover property ($fell(busoff_o));
  c_tx_irq: cover property ($rose(chan_tx_irq_o));
endmodule

bind cces_top cces_top_sva #(.BOFF_LIM(BOFF_LIM)) i_sva (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .reg_wdata_i(reg_wdata_i),
  .bit_tick_i(bit_tick_i), .tec_i(tec_i), .abort_done_i(abort_done_i),
  .chan_mode_o(chan_mode_o), .busoff_o(busoff_o),
  .chan_err_irq_o(chan_err_irq_o), .chan_tx_irq_o(chan_tx_irq_o));

//--- verif/cces_top_tb.sv
// self-checking bench for the channel error supervisor
// assumes shortened recovery and lockup counts on the design
`timescale 1ns/1ps

module cces_top_tb;
  import cces_pkg::*;
  localparam int unsigned RR = 3; // recessive bits per run
  localparam int unsigned RS = 2; // runs to recover
  localparam int unsigned LB = 4; // dominant bits to lockup
  logic        mclk_i, rst_b_i, reg_wr_i, reg_rd_i, can_rx_i, can_tx_i;
  logic        bit_tick_i, bit_chk_i, ovl_evt_i, arb_lost_i, abort_done_i;
  logic        comm_active_i, busoff_o, chan_err_irq_o, chan_tx_irq_o;
  logic        dom, fault;
  logic [3:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, exp;
  logic [8:0]  tec_i;
  logic [7:0]  rec_i;
  logic [1:0]  chan_mode_o;
  cces_evt_t   err_evt_i;
  logic [11:0] mseq;
  int          fail_count, n_compared;

  cces_top #(.REC_RUN(RR), .REC_SEQ(RS), .LOCK_BITS(LB)) i_dut (
    .mclk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .can_rx_i, .can_tx_i, .bit_tick_i, .bit_chk_i,
    .err_evt_i, .tec_i, .rec_i, .ovl_evt_i, .arb_lost_i, .abort_done_i,
    .comm_active_i, .chan_mode_o, .busoff_o, .chan_err_irq_o,
    .chan_tx_irq_o);
  cces_bus_node i_bus (.tx_i(can_tx_i), .dom_i(dom), .fault_i(fault),
    .rx_o(can_rx_i));

  // clock at 200 MHz
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] e);
    n_compared++;
    if (got !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 cmp(reg_rdata_o, e);
  endtask

  // one-cycle event pulse, then room for flag and interrupt
  task automatic pulse(input cces_evt_t e, input logic [2:0] o);
    @(posedge mclk_i);
    err_evt_i <= e;
    {ovl_evt_i, arb_lost_i, abort_done_i} <= o;
    @(posedge mclk_i);
    err_evt_i <= '0;
    {ovl_evt_i, arb_lost_i, abort_done_i} <= 3'h0;
    repeat (2) @(posedge mclk_i);
  endtask

  // set bus levels, let the synchroniser settle, then n sample points
  task automatic tick(input int n, input logic tx, d, f, chk);
    @(posedge mclk_i);
    can_tx_i  <= tx;
    dom       <= d;
    fault     <= f;
    bit_chk_i <= chk;
    repeat (3) @(posedge mclk_i);
    repeat (n) begin
      @(posedge mclk_i);
      bit_tick_i <= 1'b1;
      @(posedge mclk_i);
      bit_tick_i <= 1'b0;
    end
    repeat (2) @(posedge mclk_i);
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    wrap_up();
  end

  initial begin
    {reg_wr_i, reg_rd_i, bit_tick_i, bit_chk_i, dom, fault} = 6'h0;
    {ovl_evt_i, arb_lost_i, abort_done_i, comm_active_i} = 4'h0;
    {reg_addr_i, reg_wdata_i, tec_i, rec_i} = '0;
    err_evt_i = '0;
    can_tx_i = 1'b1;
    fail_count = 0;
    n_compared = 0;
    mseq = {2'h2, 2'h0, 2'h1, 2'h2, 2'h1, 2'h0};
    rst_b_i = 1'b0;
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    // reset values and an unmapped read
    rd(ADDR_CTRL, 32'h1000);
    rd(ADDR_STAT, 32'h1);
    rd(4'hc, 32'h0);
    // first-error display with simultaneous kinds
    wr(ADDR_CTRL, 32'hff);
    pulse(cces_evt_t'(5'h0a), 3'h0);
    #1 cmp(chan_err_irq_o, 1);
    pulse(cces_evt_t'(5'h01), 3'h0);
    rd(ADDR_FLAGS, 32'h0a01);
    wr(ADDR_FLAGS, 32'h7fff);
    rd(ADDR_FLAGS, 32'h0);
    cmp(chan_err_irq_o, 0);
    // all-errors display, interrupts disabled
    wr(ADDR_CTRL, 32'h800);
    pulse(cces_evt_t'(5'h08), 3'h0);
    exp = 32'h0901;
    for (int i = 0; i < 5; i++) begin
      pulse(cces_evt_t'(5'h01 << i), 3'h0);
      exp = exp | (32'h100 << (i == 4 ? 6 : i));
      rd(ADDR_FLAGS, exp);
    end
    tick(1, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(ADDR_FLAGS, exp | 32'h2000);
    tick(1, 1'b1, 1'b1, 1'b0, 1'b1);
    rd(ADDR_FLAGS, exp | 32'h3000);
    cmp(chan_err_irq_o, 0);
    wr(ADDR_FLAGS, 32'h7fff);
    // overload, arbitration loss, abort completion
    wr(ADDR_CTRL, 32'h1a0);
    pulse('0, 3'h4);
    rd(ADDR_FLAGS, 32'h20);
    cmp(chan_err_irq_o, 1);
    pulse('0, 3'h2);
    rd(ADDR_FLAGS, 32'ha0);
    pulse('0, 3'h1);
    #1 cmp(chan_tx_irq_o, 1);
    rd(ADDR_STAT, 32'h20);
    wr(ADDR_STAT, 32'h20);
    wr(ADDR_FLAGS, 32'hff);
    repeat (2) @(posedge mclk_i);
    #1 cmp({chan_tx_irq_o, chan_err_irq_o}, 0);
    // warning and passive fire once on entry
    @(posedge mclk_i) tec_i <= 9'd96;
    repeat (3) @(posedge mclk_i);
    rd(ADDR_FLAGS, 32'h2);
    @(posedge mclk_i) rec_i <= 8'd128;
    repeat (3) @(posedge mclk_i);
    rd(ADDR_FLAGS, 32'h6);
    wr(ADDR_FLAGS, 32'hff);
    repeat (3) @(posedge mclk_i);
    rd(ADDR_FLAGS, 32'h0);
    @(posedge mclk_i) {tec_i, rec_i} <= '0;
    // every recovery selection: entry, optional halt, recovery
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_CTRL, 32'(b) << CTRL_BOM_LSB);
      @(posedge mclk_i) tec_i <= 9'h100;
      repeat (3) @(posedge mclk_i);
      tec_i <= 9'h0;
      #1 cmp(busoff_o, 1);
      cmp(chan_mode_o, b == 1 ? MODE_HALT : MODE_COMM);
      if (b == 3) begin
        wr(ADDR_CTRL, 32'h4600);
        rd(ADDR_CTRL, 32'h2600);
      end
      tick(RR * RS, 1'b1, 1'b0, 1'b0, 1'b0);
      cmp(busoff_o, 0);
      cmp(chan_mode_o, b == 0 ? MODE_COMM : MODE_HALT);
      rd(ADDR_FLAGS, 32'h1e);
      wr(ADDR_FLAGS, 32'hff);
    end
    // lockup: a short dominant run restarts, a full one declares
    wr(ADDR_CTRL, 32'h40);
    @(posedge mclk_i) comm_active_i <= 1'b1;
    tick(LB - 1, 1'b1, 1'b1, 1'b0, 1'b0);
    tick(1, 1'b1, 1'b0, 1'b0, 1'b0);
    rd(ADDR_FLAGS, 32'h0);
    tick(LB, 1'b1, 1'b1, 1'b0, 1'b0);
    rd(ADDR_FLAGS, 32'h40);
    cmp(chan_err_irq_o, 1);
    // channel mode requests from every mode; code 3 ignored
    for (int k = 0; k < 6; k++) begin
      wr(ADDR_CTRL, 32'(mseq[11-2*k -: 2]) << CTRL_MODE_LSB);
      #1 cmp(chan_mode_o, mseq[11-2*k -: 2]);
    end
    wr(ADDR_CTRL, 32'h3000);
    #1 cmp(chan_mode_o, MODE_COMM);
    wrap_up();
  end
endmodule
